// >>> rtl/seq_status_pkg.sv
// Package: register map, status codes, steps and bus structs for target sequence status
package seq_status_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_IRQ_CAUSE = 8'h05;
  localparam logic [7:0] IDX_SEQUENCE_STEP = 8'h06;
  localparam logic [7:0] IDX_SYNC_BYTE_PERIOD = 8'h06;
  localparam logic [7:0] IDX_SEQ_CONTROL = 8'h10;
  localparam logic [7:0] IDX_SEQ_FLAGS = 8'h11;
  localparam logic [7:0] IDX_FIFO_DATA = 8'h12;
  localparam logic [7:0] IDX_CLOCKS_PER_BYTE = 8'h13;

  // Interrupt status codes
  localparam logic [7:0] CODE_SEL_NOATN = 8'h01;
  localparam logic [7:0] CODE_SEL_NOATN_ATN = 8'h11;
  localparam logic [7:0] CODE_SEL_ATN = 8'h02;
  localparam logic [7:0] CODE_SEL_ATN_ATN = 8'h12;
  localparam logic [7:0] CODE_RECV_CMD = 8'h08;
  localparam logic [7:0] CODE_ATN_HALT = 8'h18;
  localparam logic [7:0] CODE_BUS_FREE = 8'h28;
  localparam logic [7:0] ATN_CODE_BIT = 8'h10;

  // Internal step values
  localparam logic [2:0] STEP_0 = 3'h0;
  localparam logic [2:0] STEP_1 = 3'h1;
  localparam logic [2:0] STEP_2 = 3'h2;
  localparam logic [2:0] STEP_4 = 3'h4;
  localparam logic [2:0] STEP_5 = 3'h5;
  localparam logic [2:0] STEP_6 = 3'h6;

  // Synchronous period
  localparam logic [4:0] PERIOD_RESET = 5'h05;
  localparam logic [4:0] PERIOD_MIN = 5'h04;
  localparam logic [5:0] PERIOD_WRAP_ADD = 6'h20;

  // Sequence commands (seq_control bits 2:0)
  localparam logic [2:0] CMD_SEL_NOATN = 3'h1;
  localparam logic [2:0] CMD_SEL_ATN = 3'h2;
  localparam logic [2:0] CMD_RECV_CMD = 3'h3;
  localparam logic [2:0] CMD_DISCONNECT = 3'h4;
  localparam logic [2:0] CMD_TERMINATE = 3'h5;
  localparam int CTRL_EXT_MSG_BIT = 3;
  localparam int CTRL_START_BIT = 7;

  localparam logic [7:0] NULL_MSG = 8'h00;
  localparam logic [7:0] IDENTIFY_BIT = 8'h80;
  localparam int CDB_MAX = 12;
  localparam logic [31:0] BUS_ERR_ZERO = 32'h0000_0000;

  typedef enum logic [2:0] {
    CL_NONE, CL_SEL, CL_MSG, CL_CMD, CL_SENT
  } byte_class_t;

  // One byte event from the SCSI phase engine
  typedef struct packed {
    logic valid;
    byte_class_t cls;
    logic [7:0] data;
    logic parity_err;
    logic last;
  } bus_byte_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

endpackage : seq_status_pkg

// >>> rtl/seq_status.sv
// Target-mode sequence status, receive FIFO load and synchronous period register
//
// Summary of operation
// - Select without ATN, full CDB: step 2, code 01
// - Select without ATN, CDB parity error: step 1, 01
// - ATN during command phase gives code 11
// - Select without ATN: bus ID then null message queued
// - Select ATN, option clear: one msg, CDB, step 2/02
// - Store ID and msg; bad msg halts step 0
// - Option clear, ATN held after msg: step 0/12
// - Option clear, CDB parity: step 1, 02 or 12
// - Option set: three msgs, CDB, step 6/02
// - Option set, ATN still true at end: 6/12
// - Option set, CDB parity after three msgs: step 5
// - Bad msg 2/3 or ATN held: step 4
// - ATN dropped after one msg: step 2 or 1
// - Receive command complete: step 2, 08 or 18
// - Receive command parity error: step 1, 08/18
// - Disconnect complete: bus free, step 2, 28
// - Disconnect ATN halt: 18, step 0 or 1
// - Terminate complete: bus free, step 2, 28
// - Terminate ATN halt: 18, step 0 or 1
// - Five-bit period in clocks per byte, minimum 4
// - Reset sets period to five clocks
// - Period bits 7:5 reserved, read zero
// - Codes 0..3 mean 32..35 clocks
`timescale 1ns/10ps
module seq_status
  import seq_status_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk, // 40 MHz clock
  input wire logic rstn, // Async reset, active low
  input wire logic soft_reset, // Soft reset pulse, same clock
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [7:0] bus_data, // SCSI byte from the phase engine
  input wire logic bus_valid, // Byte strobe
  input wire logic [2:0] bus_class, // Byte class
  input wire logic bus_parity_err, // Parity error on this byte
  input wire logic bus_last, // Last CDB byte or last sent byte
  input wire logic atn_pin, // ATN from SCSI bus
  output logic seq_busy, // Sequence running
  output logic seq_done, // Completion or halt pulse
  output logic bus_free, // Target released bus
  output logic [4:0] period_code, // Programmed period code
  output logic [5:0] clocks_per_byte // Decoded clocks per byte
);

  initial begin
    if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256) $error("FIFO_DEPTH out of range");
  end

  localparam int AW = $clog2(FIFO_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Synchroniser for ATN; the first stage is read only by the second

  logic atn_s1_r;
  logic atn_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      atn_s1_r <= 1'b0;
      atn_r <= 1'b0;
    end else begin
      atn_s1_r <= atn_pin;
      atn_r <= atn_s1_r;
    end
  end

  bus_byte_t in_b;
  always_comb begin
    in_b.valid = bus_valid;
    in_b.cls = byte_class_t'(bus_class);
    in_b.data = bus_data;
    in_b.parity_err = bus_parity_err;
    in_b.last = bus_last;
  end

  function automatic logic [5:0] decode_period(input logic [4:0] code);
    if (code < PERIOD_MIN) begin
      decode_period = PERIOD_WRAP_ADD + {1'b0, code};
    end else begin
      decode_period = {1'b0, code};
    end
  endfunction : decode_period

  ////////////////////////////////////////////////////////////////////////////
  // APB decode

  logic setup_ph;
  logic wr_acc;
  logic rd_acc;
  logic [9:0] widx;
  logic idx_hit;
  assign setup_ph = psel && !penable;
  assign widx = paddr[11:2];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign idx_hit = (paddr[1:0] == 2'b00) && (widx[9:8] == 2'b00) && (
    widx[7:0] == IDX_IRQ_CAUSE || widx[7:0] == IDX_SEQUENCE_STEP ||
    widx[7:0] == IDX_SEQ_CONTROL || widx[7:0] == IDX_SEQ_FLAGS ||
    widx[7:0] == IDX_FIFO_DATA || widx[7:0] == IDX_CLOCKS_PER_BYTE);

  ////////////////////////////////////////////////////////////////////////////
  // Sequence state machine

  typedef enum {
    S_IDLE, S_SEL_ID, S_MSG1, S_MSG23, S_CDB, S_SEND
  } seq_state_t;

  seq_state_t state_r;
  logic [2:0] cmd_r;
  logic ext_r;
  logic [1:0] msg_cnt_r;
  logic sent_cnt_r;
  logic [2:0] step_r;
  logic [7:0] code_r;
  logic [7:0] base_code;
  logic start_req;
  logic finish;
  logic [2:0] fin_step;
  logic [7:0] fin_code;
  logic push;
  logic [7:0] push_data;
  logic push_null_r;

  assign start_req = wr_acc && idx_hit && widx[7:0] == IDX_SEQ_CONTROL && pwdata[CTRL_START_BIT];

  always_comb begin
    case (cmd_r)
      CMD_SEL_NOATN: base_code = CODE_SEL_NOATN;
      CMD_SEL_ATN: base_code = CODE_SEL_ATN;
      CMD_RECV_CMD: base_code = CODE_RECV_CMD;
      default: base_code = CODE_BUS_FREE;
    endcase
  end

  // Decide completions and halts, and which bytes go to the FIFO
  always_comb begin
    finish = 1'b0;
    fin_step = STEP_0;
    fin_code = base_code;
    push = 1'b0;
    push_data = in_b.data;
    if (push_null_r) begin
      push = 1'b1;
      push_data = NULL_MSG;
    end else if (in_b.valid) begin
      case (state_r)
        S_SEL_ID: begin
          push = in_b.cls == CL_SEL;
        end
        S_MSG1: begin
          push = in_b.cls == CL_MSG;
          if (in_b.cls == CL_MSG && (in_b.parity_err || !in_b.data[7])) begin
            finish = 1'b1;
            fin_step = STEP_0;
            fin_code = atn_r ? CODE_SEL_ATN_ATN : CODE_SEL_ATN;
          end else if (in_b.cls == CL_MSG && atn_r && !ext_r) begin
            finish = 1'b1;
            fin_step = STEP_0;
            fin_code = CODE_SEL_ATN_ATN;
          end
        end
        S_MSG23: begin
          push = in_b.cls == CL_MSG;
          if (in_b.cls == CL_MSG && in_b.parity_err) begin
            finish = 1'b1;
            fin_step = STEP_4;
            fin_code = CODE_SEL_ATN;
          end else if (in_b.cls == CL_MSG && msg_cnt_r == 2'd2 && atn_r) begin
            finish = 1'b1;
            fin_step = STEP_4;
            fin_code = CODE_SEL_ATN_ATN;
          end
        end
        S_CDB: begin
          push = in_b.cls == CL_CMD;
          if (in_b.cls == CL_CMD && (in_b.parity_err || in_b.last)) begin
            finish = 1'b1;
            fin_code = atn_r ? (base_code | ATN_CODE_BIT) : base_code;
            if (msg_cnt_r == 2'd3) begin
              fin_step = in_b.parity_err ? STEP_5 : STEP_6;
            end else begin
              fin_step = in_b.parity_err ? STEP_1 : STEP_2;
            end
            if (cmd_r == CMD_RECV_CMD) begin
              fin_code = atn_r ? CODE_ATN_HALT : CODE_RECV_CMD;
            end
          end
        end
        S_SEND: begin
          if (in_b.cls == CL_SENT && atn_r) begin
            finish = 1'b1;
            fin_step = sent_cnt_r ? STEP_1 : STEP_0;
            fin_code = CODE_ATN_HALT;
          end else if (in_b.cls == CL_SENT && in_b.last) begin
            finish = 1'b1;
            fin_step = STEP_2;
            fin_code = CODE_BUS_FREE;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= S_IDLE;
      cmd_r <= 3'h0;
      ext_r <= 1'b0;
      msg_cnt_r <= 2'd0;
      sent_cnt_r <= 1'b0;
      push_null_r <= 1'b0;
    end else if (soft_reset) begin
      state_r <= S_IDLE;
      push_null_r <= 1'b0;
    end else begin
      push_null_r <= 1'b0;
      if (finish) begin
        state_r <= S_IDLE;
      end else begin
        case (state_r)
          S_IDLE: begin
            if (start_req) begin
              cmd_r <= pwdata[2:0];
              ext_r <= pwdata[CTRL_EXT_MSG_BIT];
              msg_cnt_r <= 2'd0;
              sent_cnt_r <= 1'b0;
              case (pwdata[2:0])
                CMD_SEL_NOATN, CMD_SEL_ATN: state_r <= S_SEL_ID;
                CMD_RECV_CMD: state_r <= S_CDB;
                CMD_DISCONNECT, CMD_TERMINATE: state_r <= S_SEND;
                default: state_r <= S_IDLE;
              endcase
            end
          end
          S_SEL_ID: begin
            if (in_b.valid && in_b.cls == CL_SEL) begin
              if (cmd_r == CMD_SEL_NOATN) begin
                push_null_r <= 1'b1;
                state_r <= S_CDB;
              end else begin
                state_r <= S_MSG1;
              end
            end
          end
          S_MSG1: begin
            if (in_b.valid && in_b.cls == CL_MSG) begin
              msg_cnt_r <= 2'd1;
              state_r <= (ext_r && atn_r) ? S_MSG23 : S_CDB;
            end
          end
          S_MSG23: begin
            if (in_b.valid && in_b.cls == CL_MSG) begin
              msg_cnt_r <= msg_cnt_r + 2'd1;
              if (msg_cnt_r == 2'd2) begin
                state_r <= S_CDB;
              end
            end
          end
          S_SEND: begin
            if (in_b.valid && in_b.cls == CL_SENT) begin
              sent_cnt_r <= 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Step and code change only together, at the done pulse or a soft reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_r <= STEP_0;
      code_r <= 8'h00;
      seq_done <= 1'b0;
      bus_free <= 1'b0;
      seq_busy <= 1'b0;
    end else if (soft_reset) begin
      step_r <= STEP_0;
      code_r <= 8'h00;
      seq_done <= 1'b0;
      bus_free <= 1'b0;
      seq_busy <= 1'b0;
    end else begin
      seq_done <= finish;
      seq_busy <= finish ? 1'b0 : (state_r != S_IDLE || start_req);
      if (finish) begin
        step_r <= fin_step;
        code_r <= fin_code;
        bus_free <= fin_code == CODE_BUS_FREE;
      end else if (start_req) begin
        bus_free <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive FIFO; overflow drops the byte and raises a sticky flag

  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic ovf_r;
  logic pop;
  logic do_push;
  assign pop = rd_acc && idx_hit && widx[7:0] == IDX_FIFO_DATA && cnt_r != '0;
  assign do_push = push && cnt_r != (AW+1)'(FIFO_DEPTH);

  always_ff @(posedge clk) begin
    if (do_push) begin
      fifo_mem[wp_r] <= push_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else if (soft_reset || start_req) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      ovf_r <= 1'b0;
    end else begin
      if (do_push) begin
        wp_r <= (wp_r == AW'(FIFO_DEPTH - 1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(FIFO_DEPTH - 1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(do_push) - (AW+1)'(pop);
      if (push && !do_push) begin
        ovf_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronous period register

  logic [4:0] period_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_r <= PERIOD_RESET;
    end else if (soft_reset) begin
      period_r <= PERIOD_RESET;
    end else if (wr_acc && idx_hit && widx[7:0] == IDX_SYNC_BYTE_PERIOD) begin
      period_r <= pwdata[4:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      period_code <= PERIOD_RESET;
      clocks_per_byte <= {1'b0, PERIOD_RESET};
    end else begin
      period_code <= period_r;
      clocks_per_byte <= decode_period(period_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: no wait states, registered read data

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= BUS_ERR_ZERO;
    end else begin
      pready <= setup_ph;
      pslverr <= setup_ph && !idx_hit;
      if (setup_ph && !pwrite) begin
        case (widx[7:0])
          IDX_IRQ_CAUSE: prdata <= {24'h00_0000, code_r};
          IDX_SEQUENCE_STEP: prdata <= {29'h0000_0000, step_r};
          IDX_SEQ_CONTROL: prdata <= {24'h00_0000, 4'h0, ext_r, cmd_r};
          IDX_SEQ_FLAGS: prdata <= (32'(cnt_r) << 5) | {29'h0000_0000, ovf_r, bus_free, seq_busy};
          IDX_FIFO_DATA: prdata <= {24'h00_0000, fifo_mem[rp_r]};
          IDX_CLOCKS_PER_BYTE: prdata <= {26'h000_0000, decode_period(period_r)};
          default: prdata <= BUS_ERR_ZERO;
        endcase
      end
    end
  end

endmodule : seq_status

// >>> test/seq_status_chk.sv
// Checker for the target sequence status block, bound to its ports
`timescale 1ns/10ps
module seq_status_chk
  import seq_status_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic soft_reset, // Soft reset
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic bus_valid, // Byte strobe
  input wire logic [2:0] bus_class, // Byte class
  input wire logic bus_last, // Last byte
  input wire logic seq_busy, // Running
  input wire logic seq_done, // Done pulse
  input wire logic bus_free, // Bus released
  input wire logic [4:0] period_code, // Period code
  input wire logic [5:0] clocks_per_byte // Decoded period
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Codes below the minimum wrap to the top of the range
  function automatic logic [5:0] dec(input logic [4:0] c);
    return (c < PERIOD_MIN) ? {1'b1, c} : {1'b0, c};
  endfunction : dec
  ////////////////////////////////////////////////////////////////
  a_done_single: assert property (seq_done |=> !seq_done)
    else $error("done pulse too long");
  a_done_cause: assert property (seq_done |-> $past(bus_valid) && $past(seq_busy))
    else $error("done without a byte");
  a_cdb_finish: assert property (seq_busy && bus_valid && bus_last &&
    bus_class == 3'h3 |=> seq_done)
    else $error("last command byte did not finish");
  a_free_done: assert property ($rose(bus_free) |-> seq_done || $past(seq_done))
    else $error("bus free without completion");
  a_free_idle: assert property (bus_free |-> !seq_busy)
    else $error("bus free while busy");
  // The period output copies the register one cycle late, hence the extra cycle
  a_period_write: assert property (psel && penable && pwrite && paddr == 12'h018 &&
    !soft_reset |=> ##1 period_code == $past(pwdata[4:0], 2))
    else $error("period write wrong");
  a_period_reset: assert property (soft_reset |=> ##1 period_code == PERIOD_RESET)
    else $error("period not reset");
  a_cpb_decode: assert property (clocks_per_byte == dec(period_code))
    else $error("clocks per byte decode");
  c_done: cover property (seq_done && !bus_free);
  c_free: cover property ($rose(bus_free));
  c_wrap: cover property (period_code < PERIOD_MIN);
endmodule : seq_status_chk

bind seq_status seq_status_chk u_chk (.clk, .rstn, .soft_reset, .psel, .penable, .pwrite, .paddr,
  .pwdata, .bus_valid, .bus_class, .bus_last, .seq_busy, .seq_done, .bus_free, .period_code,
  .clocks_per_byte);

// >>> test/initiator_model.sv
// Behavioural initiator: sends selection, message and command bytes and drives ATN
`timescale 1ns/10ps
module initiator_model (
  input wire logic clk, // Clock
  output logic [7:0] bus_data, // Byte value
  output logic bus_valid, // Byte strobe
  output logic [2:0] bus_class, // Byte class
  output logic bus_parity_err, // Parity fault
  output logic bus_last, // Last byte
  output logic atn_pin // ATN level
);
  initial begin
    bus_data = 8'h5a;
    bus_valid = 1'b0;
    bus_class = 3'h0;
    bus_parity_err = 1'b0;
    bus_last = 1'b0;
    atn_pin = 1'b0;
  end
  // ATN moves well ahead of the byte it qualifies so the synchroniser has settled
  task automatic set_atn(input logic a);
    if (a !== atn_pin) begin
      atn_pin <= a;
      repeat (3) @(posedge clk);
    end
  endtask : set_atn
  task automatic send(input logic [2:0] c, input logic [7:0] d, input logic pe, l, input int gap);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    bus_data <= d;
    bus_class <= c;
    bus_parity_err <= pe;
    bus_last <= l;
    bus_valid <= 1'b1;
    @(posedge clk);
    bus_valid <= 1'b0;
    // Released data does not hold its last value
    bus_data <= ~d;
    bus_class <= 3'h0;
    bus_parity_err <= 1'b0;
    bus_last <= 1'b0;
  endtask : send
endmodule : initiator_model

// >>> test/seq_status_test.sv
// Self-checking testbench for the target sequence status block
`timescale 1ns/10ps
module seq_status_test
  import seq_status_pkg::*;
;
  logic clk, rstn, soft_reset, psel, penable, pwrite, pready, pslverr, dseen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] bus_data;
  logic [2:0] bus_class;
  logic bus_valid, bus_parity_err, bus_last, atn_pin, seq_busy, seq_done, bus_free;
  logic [4:0] period_code, pc;
  logic [5:0] clocks_per_byte;
  logic [2:0] es;
  logic [7:0] ec;
  logic [33:0] nq[$];
  logic fq[$];
  int mismatches, samples_checked;
  seq_status DUT (.clk, .rstn, .soft_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .bus_data, .bus_valid, .bus_class, .bus_parity_err, .bus_last, .atn_pin,
    .seq_busy, .seq_done, .bus_free, .period_code, .clocks_per_byte);
  initiator_model ini (.clk, .bus_data, .bus_valid, .bus_class, .bus_parity_err, .bus_last,
    .atn_pin);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  task automatic err(input string m);
    mismatches++;
    $display("ERROR %0t %s", $time, m);
  endtask : err
  // Note n is {is_read, expected error, expected data}
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [33:0] n);
    int t;
    @(posedge clk);
    nq.push_back(n);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    t = 0;
    do begin
      @(posedge clk);
      t++;
    end while (pready !== 1'b1 && t < 50);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err("apb hang");
      close_out();
    end
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0000_0000, {2'b10, 24'h00_0000, e});
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h00_0000, d}, {2'b00, 32'h0000_0000});
  endtask : wr
  task automatic b(input logic [2:0] c, input logic [7:0] d, input logic pe, l, a);
    ini.set_atn(a);
    ini.send(c, d, pe, l, $urandom_range(0, 1));
  endtask : b
  task automatic cdb(input int n, input logic pe, a);
    for (int i = 0; i < n; i++) begin
      b(3'h3, 8'h20 + 8'(i), pe && i == n - 1, !pe && i == n - 1, a);
    end
  endtask : cdb
  task automatic st(input logic [2:0] c, input logic x);
    wr(12'h040, {4'h8, x, c});
  endtask : st
  task automatic sn(input logic a, input int n, input logic pe);
    st(3'h1, 1'b0);
    b(3'h1, 8'h04, 1'b0, 1'b0, 1'b0);
    cdb(n, pe, a);
  endtask : sn
  task automatic sa(input logic x, input logic [7:0] d, input logic pe, a);
    st(3'h2, x);
    b(3'h1, 8'h04, 1'b0, 1'b0, 1'b1);
    b(3'h2, d, pe, 1'b0, a);
  endtask : sa
  task automatic m3(input logic pe, a);
    b(3'h2, 8'h01, pe, 1'b0, 1'b1);
    if (!pe)
      b(3'h2, 8'h03, 1'b0, 1'b0, a);
  endtask : m3
  task automatic fin(input string nm, input logic [2:0] s, input logic [7:0] c, input logic f);
    int t;
    fq.push_back(f);
    t = 0;
    while (seq_done !== 1'b1 && t < 300) begin
      @(posedge clk);
      t++;
    end
    if (seq_done !== 1'b1) begin
      err("no completion");
      close_out();
    end
    rd(12'h018, {5'h00, s});
    rd(12'h014, c);
    $display("test %s done", nm);
  endtask : fin
  ////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    logic [33:0] n;
    if (psel && penable && pready) begin
      n = nq.pop_front();
      samples_checked++;
      if (pslverr !== n[32] || (n[33] && prdata !== n[31:0]))
        err($sformatf("apb %h read %h err %b", paddr, prdata, pslverr));
    end
    if (dseen) begin
      samples_checked++;
      if (bus_free !== fq.pop_front())
        err("bus free level");
    end
    dseen = seq_done === 1'b1;
  end
  initial begin
    rstn = 1'b0;
    soft_reset = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    dseen = 1'b0;
    mismatches = 0;
    samples_checked = 0;
    void'($urandom(88));
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h04C, 8'h05);
    apb(1'b0, 12'h07C, 32'h0000_0000, {2'b11, 32'h0000_0000});
    apb(1'b1, 12'h019, 32'h0000_0007, {2'b01, 32'h0000_0000});
    rd(12'h04C, 8'h05);
    for (int i = 0; i < 7; i++) begin
      pc = (i < 5) ? 5'(i) : ((i == 5) ? 5'($urandom_range(4, 31)) : 5'h1f);
      wr(12'h018, {3'b111, pc});
      rd(12'h04C, (pc < 5'h04) ? {3'b001, pc} : {3'b000, pc});
    end
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    rd(12'h04C, 8'h05);
    sn(1'b0, 6, 1'b0);
    fin("sel", 3'h2, 8'h01, 1'b0);
    apb(1'b0, 12'h044, 32'h0000_0000, {2'b10, 32'h0000_0100});
    rd(12'h048, 8'h04);
    rd(12'h048, 8'h00);
    for (int i = 0; i < 6; i++)
      rd(12'h048, 8'h20 + 8'(i));
    sn(1'b1, 6, 1'b0);
    fin("sel atn", 3'h2, 8'h11, 1'b0);
    sn(1'b0, 3, 1'b1);
    fin("sel parity", 3'h1, 8'h01, 1'b0);
    sa(1'b0, 8'h80, 1'b0, 1'b0);
    cdb(6, 1'b0, 1'b0);
    fin("atn one msg", 3'h2, 8'h02, 1'b0);
    sa(1'b0, 8'h01, 1'b0, 1'b0);
    fin("bad msg", 3'h0, 8'h02, 1'b0);
    sa(1'b0, 8'h80, 1'b1, 1'b0);
    fin("msg parity", 3'h0, 8'h02, 1'b0);
    sa(1'b0, 8'h80, 1'b0, 1'b1);
    fin("atn held", 3'h0, 8'h12, 1'b0);
    sa(1'b0, 8'h80, 1'b0, 1'b0);
    cdb(2, 1'b1, 1'b1);
    fin("cmd parity", 3'h1, 8'h12, 1'b0);
    for (int i = 0; i < 3; i++) begin
      sa(1'b1, 8'h80, 1'b0, 1'b1);
      m3(1'b0, 1'b0);
      cdb((i == 2) ? 2 : 6, i == 2, i == 1);
      es = (i == 2) ? 3'h5 : 3'h6;
      ec = (i == 1) ? 8'h12 : 8'h02;
      fin("three msg", es, ec, 1'b0);
    end
    sa(1'b1, 8'h80, 1'b0, 1'b1);
    m3(1'b1, 1'b0);
    fin("msg2 parity", 3'h4, 8'h02, 1'b0);
    sa(1'b1, 8'h80, 1'b0, 1'b1);
    m3(1'b0, 1'b1);
    fin("msg3 atn", 3'h4, 8'h12, 1'b0);
    for (int i = 0; i < 2; i++) begin
      sa(1'b1, 8'h80, 1'b0, 1'b0);
      cdb((i == 1) ? 2 : 6, i == 1, 1'b0);
      fin("atn dropped", (i == 1) ? 3'h1 : 3'h2, 8'h02, 1'b0);
    end
    for (int i = 0; i < 4; i++) begin
      st(3'h3, 1'b0);
      cdb(i[1] ? 2 : 6, i[1], i[0]);
      fin("recv", i[1] ? 3'h1 : 3'h2, i[0] ? 8'h18 : 8'h08, 1'b0);
    end
    for (int c = 4; c < 6; c++) begin
      for (int i = 0; i < 3; i++) begin
        st(3'(c), 1'b0);
        b(3'h4, 8'h0a, 1'b0, 1'b0, i == 1);
        if (i != 1)
          b(3'h4, 8'h0b, 1'b0, 1'b1, i == 2);
        es = (i == 0) ? 3'h2 : 3'(i - 1);
        ec = (i == 0) ? 8'h28 : 8'h18;
        fin("release", es, ec, i == 0);
      end
    end
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule : seq_status_test
